/* File: verilog/kmdf_pkg.sv */
// kmdf_pkg: constants and types of the keypad monitor display formatter
package kmdf_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 50000000;
  localparam int SHOW_MS = 1000;
  localparam int HOLD_MS = 2000;
  localparam int SHOW_CYC = SHOW_MS * (CLK_HZ / 1000);
  localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int TW = 27;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_MON = 8'h08;
  localparam logic [7:0] OFS_EDIT = 8'h0C;
  localparam logic [7:0] OFS_MIN = 8'h10;
  localparam logic [7:0] OFS_MAX = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_SCALE = 8'h1C;

  // ************************************************************
  // control fields and reset values
  // ************************************************************
  localparam int CTRL_HEX = 0;
  localparam int CTRL_PAGE = 1;
  localparam int CTRL_EDIT = 2;
  localparam int CTRL_EHEX = 3;
  localparam int CTRL_EWIDE = 4;
  localparam logic [4:0] RST_CTRL = 5'h00;
  localparam logic [4:0] RST_SEL = 5'h00;
  localparam logic [31:0] RST_VAL = 32'h00000000;
  localparam logic [31:0] RST_MIN = 32'h80000001;
  localparam logic [31:0] RST_MAX = 32'h7FFFFFFF;

  // ************************************************************
  // monitor items
  // ************************************************************
  localparam logic [4:0] ITEM_LAST = 5'h12;
  localparam logic [4:0] ITEM_INERTIA = 5'h0F;
  localparam logic [4:0] ITEM_RES = 5'h11;
  localparam logic [4:0] ITEM_INDEX = 5'h12;
  localparam logic [31:0] PULSE_PER_REV = 32'h00186A00;
  localparam logic [31:0] INDEX_LIM = 32'h00001388;

  // ************************************************************
  // display characters and keys
  // ************************************************************
  localparam int DEC_DIGITS = 10;
  localparam logic [4:0] CH_H = 5'h10;
  localparam logic [4:0] CH_L = 5'h11;
  localparam logic [4:0] CH_BLANK = 5'h12;
  localparam logic [4:0] CH_DASH = 5'h13;
  localparam int KEY_UP = 0;
  localparam int KEY_DOWN = 1;
  localparam int KEY_SHIFT = 2;
  localparam int KEY_SET = 3;
  localparam int KEY_N = 4;

  typedef enum logic [1:0] {PH_BANNER, PH_IDENT, PH_RUN} kmdf_phase_type;

endpackage : kmdf_pkg

/* File: verilog/kmdf_bcd.sv */
// kmdf_bcd: serial binary to packed decimal converter
`timescale 1ns/1ps
module kmdf_bcd
  import kmdf_pkg::*;
#(
  parameter int W = 32,
  parameter int D = DEC_DIGITS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // binary magnitude and its sign
  input wire logic [W-1:0] bin,
  input wire logic sgn,
  // decimal result
  output logic [4*D-1:0] bcd,
  output logic bcd_sgn
);

  logic [W-1:0] sh_ff;
  logic [4*D-1:0] acc_ff;
  logic [4*D-1:0] adj;
  logic [4*D-1:0] bcd_ff;
  logic [5:0] cnt_ff;
  logic sgn_ff;
  logic bcd_sgn_ff;
  wire [4*D-1:0] nxt_acc = {adj[4*D-2:0], sh_ff[W-1]};
  wire load = (cnt_ff == 6'h00);
  wire last = (cnt_ff == 6'(W));

  // ************************************************************
  // add three to every digit above four
  // ************************************************************
  genvar g;
  for (g = 0; g < D; g++) begin : g_adj
    assign adj[4*g+3:4*g] = (acc_ff[4*g+3:4*g] > 4'h4) ?
                            acc_ff[4*g+3:4*g] + 4'h3 : acc_ff[4*g+3:4*g];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 6'h00;
      sh_ff <= '0;
      acc_ff <= '0;
      sgn_ff <= 1'b0;
      bcd_ff <= '0;
      bcd_sgn_ff <= 1'b0;
    end else begin
      cnt_ff <= last ? 6'h00 : cnt_ff + 6'h01;
      sh_ff <= load ? bin : sh_ff << 1;
      acc_ff <= load ? '0 : nxt_acc;
      sgn_ff <= load ? sgn : sgn_ff;
      if (last) begin
        bcd_ff <= nxt_acc;
        bcd_sgn_ff <= sgn_ff;
      end
    end
  end

  assign bcd = bcd_ff;
  assign bcd_sgn = bcd_sgn_ff;

endmodule : kmdf_bcd

/* File: verilog/kmdf_top.sv */
// kmdf_top: keypad monitor display formatter with ahb-lite registers
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module kmdf_top
  import kmdf_pkg::*;
#(
  parameter int SHOW_CYCLES = SHOW_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // operator keys, high while pressed
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_shift,
  input wire logic key_set,
  // five-digit display, digit 0 rightmost
  output logic [24:0] disp_char,
  output logic [4:0] disp_dp,
  output logic [4:0] disp_blink
);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ************************************************************
  // key synchronisers
  // ************************************************************
  logic [KEY_N-1:0] key_s1_ff, key_s2_ff, key_s3_ff, key_lvl_ff;
  wire [KEY_N-1:0] key_pin = {key_set, key_shift, key_down, key_up};
  wire [KEY_N-1:0] key_agree = ~(key_s2_ff ^ key_s3_ff);
  wire [KEY_N-1:0] nxt_key_lvl = (key_s2_ff & key_agree) | (key_lvl_ff & ~key_agree);
  wire [KEY_N-1:0] key_press = nxt_key_lvl & ~key_lvl_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_s1_ff <= '0;
      key_s2_ff <= '0;
      key_s3_ff <= '0;
      key_lvl_ff <= '0;
    end else begin
      key_s1_ff <= key_pin;
      key_s2_ff <= key_s1_ff;
      key_s3_ff <= key_s2_ff;
      key_lvl_ff <= nxt_key_lvl;
    end
  end

  // ************************************************************
  // bus slave
  // ************************************************************
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff, hresp_ff;
  wire bus_take = hsel && htrans[1] && hready;

  function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = pend && (a == ofs);
  endfunction : wr_hit

  wire wr_ctrl = wr_hit(wr_pend_ff, wr_addr_ff, OFS_CTRL);
  wire wr_sel = wr_hit(wr_pend_ff, wr_addr_ff, OFS_SEL);
  wire wr_mon = wr_hit(wr_pend_ff, wr_addr_ff, OFS_MON);
  wire wr_edit = wr_hit(wr_pend_ff, wr_addr_ff, OFS_EDIT);
  wire wr_min = wr_hit(wr_pend_ff, wr_addr_ff, OFS_MIN);
  wire wr_max = wr_hit(wr_pend_ff, wr_addr_ff, OFS_MAX);

  // ************************************************************
  // state registers and their decode
  // ************************************************************
  kmdf_phase_type phase_ff, nxt_phase;
  logic [TW-1:0] tmr_ff, hold_ff;
  logic [4:0] ctrl_ff, sel_ff;
  logic [31:0] mon_ff, edit_ff, min_ff, max_ff;
  logic [2:0] cur_ff;
  logic hold_done_ff;
  logic [24:0] char_ff;
  logic [4:0] dp_ff, blink_ff;
  logic [39:0] bcd;
  logic bcd_neg;

  wire edit = ctrl_ff[CTRL_EDIT];
  wire ehex = ctrl_ff[CTRL_EHEX];
  wire page = ctrl_ff[CTRL_PAGE];
  wire tmr_done = (tmr_ff == TW'(SHOW_CYCLES - 1));
  wire mon_ok = (phase_ff != PH_BANNER) && !edit;
  wire mon_step = mon_ok && (key_press[KEY_UP] || key_press[KEY_DOWN]);
  wire edit_act = edit && (phase_ff == PH_RUN);
  wire shift_lvl = key_lvl_ff[KEY_SHIFT];

  wire [7:0] stat = {bcd_neg, hold_done_ff, 1'b0, cur_ff, phase_ff};
  wire [31:0] rd_val =
    (haddr[7:0] == OFS_CTRL) ? {27'h0000000, ctrl_ff} :
    (haddr[7:0] == OFS_SEL) ? {27'h0000000, sel_ff} :
    (haddr[7:0] == OFS_MON) ? mon_ff :
    (haddr[7:0] == OFS_EDIT) ? edit_ff :
    (haddr[7:0] == OFS_MIN) ? min_ff :
    (haddr[7:0] == OFS_MAX) ? max_ff :
    (haddr[7:0] == OFS_STAT) ? {24'h000000, stat} :
    (haddr[7:0] == OFS_SCALE) ? PULSE_PER_REV : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      wr_pend_ff <= bus_take && hwrite;
      wr_addr_ff <= bus_take ? haddr[7:0] : wr_addr_ff;
      hrdata_ff <= (bus_take && !hwrite) ? rd_val : 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  // ************************************************************
  // power-up sequence
  // ************************************************************
  // banner then code
  always_comb begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PH_BANNER: if (tmr_done) nxt_phase = PH_IDENT;
      PH_IDENT: if (tmr_done) nxt_phase = PH_RUN;
      PH_RUN: nxt_phase = PH_RUN;
      default: nxt_phase = PH_BANNER;
    endcase
    if (mon_step) nxt_phase = PH_IDENT;
  end
  wire [TW-1:0] nxt_tmr = (tmr_done || mon_step || phase_ff == PH_RUN) ?
                          '0 : tmr_ff + TW'(1);

  // ************************************************************
  // monitor selection and format
  // ************************************************************
  // codes up to 18
  wire sel_ok = (hwdata[31:5] == 27'h0000000) && (hwdata[4:0] <= ITEM_LAST);
  wire [4:0] sel_up = (sel_ff == ITEM_LAST) ? 5'h00 : sel_ff + 5'h01;
  wire [4:0] sel_dn = (sel_ff == 5'h00) ? ITEM_LAST : sel_ff - 5'h01;
  wire [4:0] nxt_sel = (wr_sel && sel_ok) ? hwdata[4:0] :
                       (mon_ok && key_press[KEY_UP]) ? sel_up :
                       (mon_ok && key_press[KEY_DOWN]) ? sel_dn : sel_ff;
  wire set_tog = mon_ok && key_press[KEY_SET];
  wire [4:0] nxt_ctrl = wr_ctrl ? hwdata[4:0] :
                        {ctrl_ff[4:1], ctrl_ff[CTRL_HEX] ^ set_tog};

  // ************************************************************
  // value editing
  // ************************************************************
  function automatic logic [31:0] step_of(input logic [2:0] c, input logic hx);
    logic [31:0] d;
    d = 32'h00000001;
    case (c)
      3'h1: d = 32'h0000000A;
      3'h2: d = 32'h00000064;
      3'h3: d = 32'h000003E8;
      3'h4: d = 32'h00002710;
      default: d = 32'h00000001;
    endcase
    step_of = hx ? (32'h00000001 << {c, 2'b00}) : d;
  endfunction : step_of

  wire [31:0] step = step_of(cur_ff, ehex);
  wire [2:0] cur_last = ehex ? 3'h3 : 3'h4;
  wire [2:0] nxt_cur = (edit_act && key_press[KEY_SHIFT]) ?
                       ((cur_ff >= cur_last) ? 3'h0 : cur_ff + 3'h1) :
                       (cur_ff > cur_last) ? 3'h0 : cur_ff;
  wire hold_hit = edit_act && !ehex && shift_lvl && !hold_done_ff &&
                  (hold_ff == TW'(HOLD_CYCLES - 1));
  wire [TW-1:0] nxt_hold = (shift_lvl && !hold_hit && !hold_done_ff) ?
                           hold_ff + TW'(1) : '0;
  wire nxt_hold_done = shift_lvl && (hold_done_ff || hold_hit);
  wire [31:0] neg_edit = 32'h00000000 - edit_ff;
  wire sign_ok = ($signed(neg_edit) >= $signed(min_ff)) &&
                 ($signed(neg_edit) <= $signed(max_ff));
  wire [31:0] nxt_edit = wr_edit ? hwdata :
                         (hold_hit && sign_ok) ? neg_edit :
                         (edit_act && key_press[KEY_UP]) ? edit_ff + step :
                         (edit_act && key_press[KEY_DOWN]) ? edit_ff - step : edit_ff;

  // ************************************************************
  // value to show
  // ************************************************************
  // index range clamp
  wire [31:0] mon_clamp =
    (sel_ff != ITEM_INDEX) ? mon_ff :
    ($signed(mon_ff) > $signed(INDEX_LIM)) ? INDEX_LIM :
    ($signed(mon_ff) < -$signed(INDEX_LIM)) ? 32'h00000000 - INDEX_LIM : mon_ff;
  wire [31:0] src = edit ? edit_ff : mon_clamp;
  wire inertia = (sel_ff == ITEM_INERTIA);
  wire is_hex = edit ? ehex : ctrl_ff[CTRL_HEX];
  wire res_half = !edit && !is_hex && (sel_ff == ITEM_RES);
  wire wide = edit ? ctrl_ff[CTRL_EWIDE] : !res_half;
  wire [15:0] half = (page && (wide || res_half)) ? src[31:16] : src[15:0];
  wire [31:0] dec_val = wide ? src :
                        res_half ? {16'h0000, half} : {{16{src[15]}}, src[15:0]};
  wire neg = dec_val[31] && !inertia;
  wire [31:0] mag = dec_val[31] ? 32'h00000000 - dec_val : dec_val;

  kmdf_bcd #(.W(32), .D(DEC_DIGITS)) u_bcd (
    .hclk(hclk),
    .hresetn(hresetn),
    .bin(mag),
    .sgn(neg),
    .bcd(bcd),
    .bcd_sgn(bcd_neg)
  );

  // ************************************************************
  // character and point generation
  // ************************************************************
  // page of digits
  wire [19:0] dec_dig = (wide && page) ? bcd[39:20] : bcd[19:0];
  logic [24:0] run_char;
  genvar i;
  for (i = 0; i < 4; i++) begin : g_dig
    assign run_char[5*i+4:5*i] = is_hex ? {1'b0, half[4*i+3:4*i]} :
                                          {1'b0, dec_dig[4*i+3:4*i]};
  end
  assign run_char[24:20] = !is_hex ? {1'b0, dec_dig[19:16]} :
                           !wide ? CH_BLANK : page ? CH_H : CH_L;
  wire [4:0] run_dp = is_hex ? 5'h00 :
                      {bcd_neg, bcd_neg, 1'b0, wide && page, wide && !page};
  wire [4:0] ones = (sel_ff >= 5'h0A) ? sel_ff - 5'h0A : sel_ff;
  wire [24:0] id_char = {CH_DASH, CH_DASH, CH_BLANK, 4'h0, sel_ff >= 5'h0A, ones};
  wire [24:0] nxt_char = (phase_ff == PH_BANNER) ? {5{CH_DASH}} :
                         (phase_ff == PH_IDENT) ? id_char : run_char;
  wire [4:0] nxt_dp = (phase_ff == PH_RUN) ? run_dp : 5'h00;
  wire [4:0] nxt_blink = edit_act ? (5'h01 << cur_ff) : 5'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= PH_BANNER;
      tmr_ff <= '0;
      ctrl_ff <= RST_CTRL;
      sel_ff <= RST_SEL;
      mon_ff <= RST_VAL;
      edit_ff <= RST_VAL;
      min_ff <= RST_MIN;
      max_ff <= RST_MAX;
      cur_ff <= 3'h0;
      hold_ff <= '0;
      hold_done_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      tmr_ff <= nxt_tmr;
      ctrl_ff <= nxt_ctrl;
      sel_ff <= nxt_sel;
      mon_ff <= wr_mon ? hwdata : mon_ff;
      edit_ff <= nxt_edit;
      min_ff <= wr_min ? hwdata : min_ff;
      max_ff <= wr_max ? hwdata : max_ff;
      cur_ff <= nxt_cur;
      hold_ff <= nxt_hold;
      hold_done_ff <= nxt_hold_done;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      char_ff <= {5{CH_BLANK}};
      dp_ff <= 5'h00;
      blink_ff <= 5'h00;
    end else begin
      char_ff <= nxt_char;
      dp_ff <= nxt_dp;
      blink_ff <= nxt_blink;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign disp_char = char_ff;
  assign disp_dp = dp_ff;
  assign disp_blink = blink_ff;

  // ************************************************************
  // checks
  // ************************************************************
  sequence banner_end_s;
    phase_ff == PH_BANNER && tmr_done;
  endsequence
  sequence ident_run_s;
    phase_ff == PH_IDENT && tmr_ff == '0 ##1 tmr_ff == ($past(mon_step) ? TW'(0) : TW'(1));
  endsequence

  banner_to_ident_a: assert property (banner_end_s |=> ident_run_s)
    else $error("banner did not hand over to item code");
  ident_to_run_a: assert property (phase_ff == PH_IDENT && tmr_done && !mon_step
    |=> phase_ff == PH_RUN ##1 disp_char == $past(run_char))
    else $error("item code did not hand over to value");
  item_wrap_a: assert property (mon_ok && key_press[KEY_UP] && !wr_sel &&
    sel_ff == ITEM_LAST |=> sel_ff == 5'h00 ##1 phase_ff == PH_IDENT)
    else $error("item step past last did not wrap");
  set_format_a: assert property (set_tog && !wr_ctrl
    |=> ctrl_ff[CTRL_HEX] != $past(ctrl_ff[CTRL_HEX]))
    else $error("set key did not toggle format");
  sign_flip_a: assert property (hold_hit && sign_ok && !wr_edit
    |=> edit_ff == 32'h00000000 - $past(edit_ff))
    else $error("sign not toggled after hold");
  sign_refuse_a: assert property (hold_hit && !sign_ok && !wr_edit
    |=> $stable(edit_ff))
    else $error("out of range sign toggle taken");
  hold_once_a: assert property (hold_done_ff && shift_lvl |-> !hold_hit [*3])
    else $error("second toggle within one hold");
  hex_no_sign_a: assert property (phase_ff == PH_RUN && is_hex
    |=> disp_dp == 5'h00)
    else $error("sign points lit in hex");
  neg_points_a: assert property (phase_ff == PH_RUN && !is_hex && bcd_neg
    |=> disp_dp[4:3] == 2'b11)
    else $error("negative decimal without sign points");
  blink_digit_a: assert property (edit_act |=> disp_blink == (5'h01 << $past(cur_ff)))
    else $error("blink not on selected digit");

endmodule : kmdf_top

/* File: tb/kmdf_keypad_model.sv */
// kmdf_keypad_model: operator keypad driving the key pins
`timescale 1ns/1ps
module kmdf_keypad_model
  import kmdf_pkg::*;
(
  // clock
  input wire logic hclk,
  // key pins, high while pressed
  output logic key_up,
  output logic key_down,
  output logic key_shift,
  output logic key_set
);
  // ****************************************
  // key levels
  // ****************************************
  logic [KEY_N-1:0] key_ff = '0;
  assign key_up = key_ff[KEY_UP];
  assign key_down = key_ff[KEY_DOWN];
  assign key_shift = key_ff[KEY_SHIFT];
  assign key_set = key_ff[KEY_SET];

  // hold one key n cycles, then stay released long enough for the sync
  task press(input int k, input int n);
    key_ff[k] <= 1'b1;
    repeat (n) @(posedge hclk);
    key_ff[k] <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask : press
endmodule : kmdf_keypad_model

/* File: tb/test_keypad_monitor_display_formatter.sv */
// test_keypad_monitor_display_formatter: self-checking bench of kmdf_top
`timescale 1ns/1ps
module test_keypad_monitor_display_formatter;
  import kmdf_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic key_up;
  logic key_down;
  logic key_shift;
  logic key_set;
  logic [24:0] disp_char;
  logic [4:0] disp_dp;
  logic [4:0] disp_blink;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] rq[$];
  logic [31:0] dq[$];
  logic rdph = 0;
  logic dgo = 0;
  logic [31:0] note;
  logic [31:0] r;

  always #10 hclk = ~hclk;

  kmdf_top #(.SHOW_CYCLES(20), .HOLD_CYCLES(40)) kmdf_top_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .key_up(key_up), .key_down(key_down), .key_shift(key_shift),
    .key_set(key_set), .disp_char(disp_char), .disp_dp(disp_dp), .disp_blink(disp_blink));
  kmdf_keypad_model kmdf_keypad_model_i (.hclk(hclk), .key_up(key_up), .key_down(key_down),
    .key_shift(key_shift), .key_set(key_set));

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task summarize;
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task hrdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n > 50) begin
        err_count++;
        summarize();
      end
    end
  endtask : hrdy

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
    input logic [31:0] ex);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hrdy();
    if (c) rq.push_back(ex);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hrdy();
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 1'b0, 32'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ex);
    ahb(1'b0, a, 32'h0, 1'b1, ex);
  endtask : rd

  task dexp(input logic [31:0] ex);
    dq.push_back(ex);
    dgo <= 1'b1;
    @(posedge hclk);
    dgo <= 1'b0;
  endtask : dexp

  task show(input logic [7:0] a, input logic [31:0] v, input logic [4:0] c,
    input logic [31:0] ex);
    wr(a, v);
    wr(OFS_CTRL, {27'h0, c});
    repeat (120) @(posedge hclk);
    dexp(ex);
  endtask : show

  function logic [24:0] dg(input logic [4:0] c4, input logic [15:0] h);
    return {c4, 1'b0, h[15:12], 1'b0, h[11:8], 1'b0, h[7:4], 1'b0, h[3:0]};
  endfunction : dg

  function logic [31:0] fu(input logic [4:0] dp, input logic [24:0] c);
    return {2'h0, dp, c};
  endfunction : fu

  function logic [31:0] co(input logic [24:0] c);
    return {7'h40, c};
  endfunction : co

  // oldest note is compared whenever a result appears
  always @(posedge hclk) begin
    if (rdph) begin
      check(hrdata, rq.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
    if (dgo) begin
      note = dq.pop_front();
      if (note[31]) check({7'h0, disp_char}, {7'h0, note[24:0]});
      else if (note[30]) check({27'h0, disp_blink}, {27'h0, note[4:0]});
      else check({2'h0, disp_dp, disp_char}, note);
    end
    rdph <= hsel && htrans[1] && hreadyout && !hwrite;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(79715));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    dexp(co({5{CH_DASH}}));
    rd(OFS_CTRL, 32'h0);
    rd(OFS_SEL, 32'h0);
    rd(OFS_MIN, RST_MIN);
    rd(OFS_MAX, RST_MAX);
    rd(OFS_SCALE, PULSE_PER_REV);
    rd(8'h20, 32'h0);
    repeat (12) @(posedge hclk);
    dexp(co({CH_DASH, CH_DASH, CH_BLANK, 10'h0}));
    rd(OFS_STAT, 32'h1);
    repeat (20) @(posedge hclk);
    rd(OFS_STAT, 32'h2);
    show(OFS_MON, 32'h499602D2, 5'h00, fu(5'h01, dg(5'h6, 16'h7890)));
    show(OFS_MON, 32'h499602D2, 5'h02, fu(5'h02, dg(5'h1, 16'h2345)));
    show(OFS_MON, 32'hFFFFCFC7, 5'h00, fu(5'h19, dg(5'h1, 16'h2345)));
    show(OFS_MON, 32'hFFFFCFC7, 5'h01, fu(5'h00, dg(CH_L, 16'hCFC7)));
    for (int i = 0; i < 3; i++) begin
      r = $urandom;
      show(OFS_MON, r, 5'h01, fu(5'h00, dg(CH_L, r[15:0])));
      show(OFS_MON, r, 5'h03, fu(5'h00, dg(CH_H, r[31:16])));
    end
    wr(OFS_MON, 32'd130);
    show(OFS_SEL, 32'hF, 5'h00, fu(5'h01, dg(5'h0, 16'h0130)));
    wr(OFS_MON, 32'h00C80064);
    show(OFS_SEL, 32'h11, 5'h00, co(dg(5'h0, 16'h0100)));
    show(OFS_SEL, 32'h11, 5'h02, co(dg(5'h0, 16'h0200)));
    wr(OFS_MON, 32'hFFFFE890);
    show(OFS_SEL, 32'h12, 5'h00, fu(5'h19, dg(5'h0, 16'h5000)));
    wr(OFS_SEL, 32'h13);
    rd(OFS_SEL, 32'h12);
    kmdf_keypad_model_i.press(KEY_UP, 8);
    rd(OFS_SEL, 32'h0);
    kmdf_keypad_model_i.press(KEY_DOWN, 8);
    rd(OFS_SEL, 32'h12);
    kmdf_keypad_model_i.press(KEY_SET, 8);
    rd(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h14);
    wr(OFS_EDIT, 32'h0);
    kmdf_keypad_model_i.press(KEY_UP, 8);
    rd(OFS_EDIT, 32'h1);
    kmdf_keypad_model_i.press(KEY_SHIFT, 8);
    kmdf_keypad_model_i.press(KEY_UP, 8);
    rd(OFS_EDIT, 32'hB);
    rd(OFS_STAT, 32'h6);
    dexp(32'h40000002);
    kmdf_keypad_model_i.press(KEY_SHIFT, 100);
    rd(OFS_EDIT, 32'hFFFFFFF5);
    wr(OFS_MIN, 32'h0);
    wr(OFS_EDIT, 32'hB);
    kmdf_keypad_model_i.press(KEY_SHIFT, 60);
    rd(OFS_EDIT, 32'hB);
    show(OFS_EDIT, 32'h4D2, 5'h04, co(dg(5'h0, 16'h1234)));
    show(OFS_EDIT, 32'h1234, 5'h0C, co(dg(CH_BLANK, 16'h1234)));
    repeat (4) @(posedge hclk);
    summarize();
  end
endmodule : test_keypad_monitor_display_formatter
